// >>> logic/rbdac_top.sv
// Reset merge, brownout, code protection gating and debug mode selection
`timescale 1ns/100ps
`include "rbdac_params.svh"
module rbdac_top #(
  parameter logic [31:0] PAT_PROT_ONE = 32'h0000_0011,
  parameter logic [31:0] PAT_PROT_TWO = 32'h0000_0022,
  parameter logic [31:0] PAT_PROT_THREE = 32'h0000_0033,
  parameter logic [31:0] PAT_NO_ENTRY = 32'h0000_0044
) (
  input wire logic mclk,
  input wire logic resetn,
  // Sources
  input wire logic resetPinN,
  input wire logic wdtResetReq,
  input wire logic porDetect,
  input wire logic supplyOk,
  input wire logic [3:0] vddBelowLevel,
  // Oscillator and flash controller
  output logic ircStart,
  output logic flashInit,
  input wire logic flashInitDone,
  input wire logic [31:0] protWord,
  // Processor
  output logic sysResetN,
  output logic cpuFetchStart,
  output logic [31:0] cpuFetchAddr,
  output logic bodIrq,
  // Access gating
  output logic swdEnable,
  output logic debugApEnable,
  output logic iapEnable,
  output logic entryPinHonor,
  output logic [3:0] ispCmdSet,
  output logic jtagMode,
  // Port zero pins 0..3
  input wire logic [3:0] p0In,
  output logic [3:0] p0Out,
  output logic [3:0] p0OeN,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOeN,
  output logic [3:0] gpioIn,
  output logic jtagTms,
  output logic jtagTck,
  output logic jtagTdi,
  input wire logic jtagTdo,
  input wire logic jtagTdoEn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // A low of the least width always spans one edge, so one sample is enough
  localparam int PULSE_CYC_RAW = `RBDAC_PIN_PULSE_NS / `RBDAC_CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] pinSync_q;
  logic [1:0] porSync_q;
  logic [1:0] okSync_q;
  logic [3:0] vddMeta_q;
  logic [3:0] vddSync_q;
  logic [3:0] p0Meta_q;
  logic [3:0] p0Sync_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pinSync_q <= `RBDAC_PINSYNC_RST;
      porSync_q <= 2'h0;
      okSync_q <= 2'h0;
      vddMeta_q <= 4'h0;
      vddSync_q <= 4'h0;
      p0Meta_q <= 4'h0;
      p0Sync_q <= 4'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], resetPinN};
      porSync_q <= {porSync_q[0], porDetect};
      okSync_q <= {okSync_q[0], supplyOk};
      vddMeta_q <= vddBelowLevel;
      vddSync_q <= vddMeta_q;
      p0Meta_q <= p0In;
      p0Sync_q <= p0Meta_q;
    end
  end

  logic pinHigh;
  assign pinHigh = pinSync_q[1];

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  logic [1:0] irqSel_q;
  logic [1:0] rstSel_q;
  logic bodRstEn_q;
  logic [3:0] srcFlag_q;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  logic [3:0] lowCnt_q;
  logic pinReq;
  logic bodRstReq;
  logic [3:0] srcHit;
  logic anySrc;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lowCnt_q <= 4'h0;
    end else if (pinHigh) begin
      lowCnt_q <= 4'h0;
    end else if (lowCnt_q != 4'hF) begin
      lowCnt_q <= lowCnt_q + 4'h1;
    end
  end

  // Widened so a saturated count cannot wrap and drop a held request
  assign pinReq = !pinHigh && ({1'b0, lowCnt_q} + 5'h01 >= {1'b0, PULSE_CYC_W});
  assign bodRstReq = bodRstEn_q && vddSync_q[rstSel_q];
  assign bodIrq = vddSync_q[irqSel_q];

  always_comb begin
    srcHit = 4'h0;
    srcHit[`RBDAC_SRC_PIN_BIT] = pinReq;
    srcHit[`RBDAC_SRC_WDT_BIT] = wdtResetReq;
    srcHit[`RBDAC_SRC_POR_BIT] = porSync_q[1];
    srcHit[`RBDAC_SRC_BOD_BIT] = bodRstReq;
  end
  assign anySrc = |srcHit;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  rbdac_rst_if rstIf ();
  rbdac_pkg::rbdac_seq_t seq_q;
  logic initIssued_q;
  logic assert_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      seq_q <= rbdac_pkg::SEQ_HOLD;
    end else begin
      unique case (seq_q)
        rbdac_pkg::SEQ_HOLD: begin
          if (!anySrc && initIssued_q && flashInitDone) begin
            seq_q <= rbdac_pkg::SEQ_RUN;
          end
        end
        rbdac_pkg::SEQ_RUN: begin
          if (anySrc) begin
            seq_q <= rbdac_pkg::SEQ_HOLD;
          end
        end
      endcase
    end
  end

  // Oscillator and flash restart wait for a usable supply
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      initIssued_q <= 1'b0;
      ircStart <= 1'b0;
      flashInit <= 1'b0;
    end else begin
      ircStart <= 1'b0;
      flashInit <= 1'b0;
      if (seq_q == rbdac_pkg::SEQ_RUN) begin
        initIssued_q <= 1'b0;
      end else if (!initIssued_q && okSync_q[1]) begin
        initIssued_q <= 1'b1;
        ircStart <= 1'b1;
        flashInit <= 1'b1;
      end
    end
  end

  // Registered so the asynchronous clear never sees a combinational glitch
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      assert_q <= 1'b1;
    end else begin
      assert_q <= anySrc || (seq_q != rbdac_pkg::SEQ_RUN);
    end
  end

  assign rstIf.assertReq = assert_q;

  rbdac_reset_sync #(
    .STAGES(`RBDAC_SYNC_STAGES)
  ) uSync (
    .mclk(mclk),
    .rst(rstIf)
  );

  assign sysResetN = rstIf.chipRstN;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cpuFetchStart <= 1'b0;
      cpuFetchAddr <= `RBDAC_BOOT_ADDR;
    end else begin
      cpuFetchStart <= rstIf.releasePulse;
      cpuFetchAddr <= `RBDAC_BOOT_ADDR;
    end
  end

  // ----------------------------------------
  // Code read protection
  // ----------------------------------------
  rbdac_pkg::rbdac_prot_t prot_q;
  logic noEntry_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prot_q <= rbdac_pkg::PROT_NONE;
      noEntry_q <= 1'b0;
    end else if (seq_q == rbdac_pkg::SEQ_HOLD && initIssued_q && flashInitDone) begin
      noEntry_q <= (protWord == PAT_NO_ENTRY);
      if (protWord == PAT_PROT_ONE) begin
        prot_q <= rbdac_pkg::PROT_ONE;
      end else if (protWord == PAT_PROT_TWO) begin
        prot_q <= rbdac_pkg::PROT_TWO;
      end else if (protWord == PAT_PROT_THREE) begin
        prot_q <= rbdac_pkg::PROT_THREE;
      end else begin
        prot_q <= rbdac_pkg::PROT_NONE;
      end
    end
  end

  always_comb begin
    unique case (prot_q)
      rbdac_pkg::PROT_ONE: ispCmdSet = rbdac_pkg::ISP_NO_SECT0;
      rbdac_pkg::PROT_TWO: ispCmdSet = rbdac_pkg::ISP_ERASE_ALL;
      rbdac_pkg::PROT_THREE: ispCmdSet = rbdac_pkg::ISP_BLOCKED;
      default: ispCmdSet = rbdac_pkg::ISP_FULL;
    endcase
  end

  assign iapEnable = 1'b1;
  assign entryPinHonor = !noEntry_q && (prot_q != rbdac_pkg::PROT_THREE);

  // ----------------------------------------
  // Debug mode selection and pin routing
  // ----------------------------------------
  assign jtagMode = !pinHigh;
  assign swdEnable = pinHigh && rstIf.chipRstN
    && (prot_q == rbdac_pkg::PROT_NONE);
  // Boundary scan has no path to the debug access port
  assign debugApEnable = swdEnable;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gPin
      if (gi == 3) begin : gOut
        assign p0Out[gi] = jtagMode ? jtagTdo : gpioOut[gi];
        assign p0OeN[gi] = jtagMode ? !jtagTdoEn : gpioOeN[gi];
      end else begin : gIn
        assign p0Out[gi] = jtagMode ? 1'b0 : gpioOut[gi];
        assign p0OeN[gi] = jtagMode ? 1'b1 : gpioOeN[gi];
      end
      assign gpioIn[gi] = jtagMode ? 1'b0 : p0Sync_q[gi];
    end
  endgenerate

  assign jtagTms = jtagMode & p0Sync_q[0];
  assign jtagTck = jtagMode & p0Sync_q[1];
  assign jtagTdi = jtagMode & p0Sync_q[2];

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [3:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [3:0] clrMask;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q == `RBDAC_OFF_CTRL || awAddr_q == `RBDAC_OFF_RSTSRC)
          ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control lives on chip reset so every reset restores it
  always_ff @(posedge mclk) begin
    if (!rstIf.chipRstN) begin
      {bodRstEn_q, rstSel_q, irqSel_q} <= `RBDAC_CTRL_RST;
    end else if (doWrite && awAddr_q == `RBDAC_OFF_CTRL && wStrb_q[0]) begin
      irqSel_q <= wData_q[`RBDAC_CTRL_IRQSEL_LSB +: 2];
      rstSel_q <= wData_q[`RBDAC_CTRL_RSTSEL_LSB +: 2];
      bodRstEn_q <= wData_q[`RBDAC_CTRL_RSTEN_BIT];
    end
  end

  // Cause flags survive chip reset; a new event beats a clear
  assign clrMask = (doWrite && awAddr_q == `RBDAC_OFF_RSTSRC && wStrb_q[0])
    ? wData_q[3:0] : 4'h0;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      srcFlag_q <= `RBDAC_SRC_RST;
    end else begin
      srcFlag_q <= (srcFlag_q & ~clrMask) | srcHit;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        `RBDAC_OFF_CTRL: s_axi_rdata <= {27'h0, bodRstEn_q, rstSel_q, irqSel_q};
        `RBDAC_OFF_STATUS: s_axi_rdata <= {27'h0, vddSync_q, bodIrq};
        `RBDAC_OFF_RSTSRC: s_axi_rdata <= {28'h0, srcFlag_q};
        `RBDAC_OFF_ACCESS: s_axi_rdata <= {26'h0, jtagMode, entryPinHonor, prot_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

endmodule

// >>> include/rbdac_params.svh
// Offsets, field positions, reset values and timing counts of the reset controller
`ifndef RBDAC_PARAMS_SVH
`define RBDAC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RBDAC_OFF_CTRL 4'h0
`define RBDAC_OFF_STATUS 4'h4
`define RBDAC_OFF_RSTSRC 4'h8
`define RBDAC_OFF_ACCESS 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RBDAC_CTRL_IRQSEL_LSB 0
`define RBDAC_CTRL_RSTSEL_LSB 2
`define RBDAC_CTRL_RSTEN_BIT 4
`define RBDAC_SRC_PIN_BIT 0
`define RBDAC_SRC_WDT_BIT 1
`define RBDAC_SRC_POR_BIT 2
`define RBDAC_SRC_BOD_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RBDAC_CTRL_RST 5'h00
`define RBDAC_SRC_RST 4'h0
`define RBDAC_PINSYNC_RST 2'h3
`define RBDAC_BOOT_ADDR 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define RBDAC_CLK_PERIOD_NS 40
`define RBDAC_PIN_PULSE_NS 50
`define RBDAC_SYNC_STAGES 2

`endif

// >>> include/rbdac_pkg.sv
// Types shared by the reset, brownout and debug access controller
package rbdac_pkg;

  typedef enum logic [3:0] {
    PROT_NONE  = 4'h1,
    PROT_ONE   = 4'h2,
    PROT_TWO   = 4'h4,
    PROT_THREE = 4'h8
  } rbdac_prot_t;

  typedef enum logic [3:0] {
    ISP_FULL      = 4'h1,
    ISP_NO_SECT0  = 4'h2,
    ISP_ERASE_ALL = 4'h4,
    ISP_BLOCKED   = 4'h8
  } rbdac_isp_t;

  typedef enum logic [1:0] {
    SEQ_HOLD = 2'h1,
    SEQ_RUN  = 2'h2
  } rbdac_seq_t;

endpackage

// >>> include/rbdac_rst_if.sv
// Carrier between the sequencer and the reset release synchroniser
`timescale 1ns/100ps
interface rbdac_rst_if;
  logic assertReq;
  logic chipRstN;
  logic releasePulse;

  modport ctl (output assertReq, input chipRstN, input releasePulse);
  modport sync (input assertReq, output chipRstN, output releasePulse);
endinterface

// >>> logic/rbdac_reset_sync.sv
// Chip reset: asynchronous assertion, release synchronised to mclk
`timescale 1ns/100ps
`include "rbdac_params.svh"
module rbdac_reset_sync #(
  parameter int STAGES = `RBDAC_SYNC_STAGES
) (
  input wire logic mclk,
  rbdac_rst_if.sync rst
);
  logic [STAGES-1:0] chain_q;
  logic relDone_q;

  // Assertion does not wait for an edge; release walks the chain
  always_ff @(posedge mclk or posedge rst.assertReq) begin
    if (rst.assertReq) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge mclk or posedge rst.assertReq) begin
    if (rst.assertReq) begin
      relDone_q <= 1'b0;
    end else begin
      relDone_q <= chain_q[STAGES-1];
    end
  end

  assign rst.chipRstN = chain_q[STAGES-1];
  assign rst.releasePulse = chain_q[STAGES-1] & ~relDone_q;
endmodule

// >>> tb/rbdac_top_properties.sv
// Port-level checker for the reset, brownout and access controller
`timescale 1ns/100ps
module rbdac_top_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic resetPinN,
  input wire logic wdtResetReq,
  input wire logic sysResetN,
  input wire logic cpuFetchStart,
  input wire logic [31:0] cpuFetchAddr,
  input wire logic ircStart,
  input wire logic flashInit,
  input wire logic swdEnable,
  input wire logic debugApEnable,
  input wire logic iapEnable,
  input wire logic entryPinHonor,
  input wire logic [3:0] ispCmdSet,
  input wire logic jtagMode,
  input wire logic [3:0] gpioIn,
  input wire logic [3:0] p0OeN,
  input wire logic jtagTdoEn
);
  // ----------------------------------------
  // Reset merge and release
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_pin_to_reset: assert property (!resetPinN [*4] |-> !sysResetN)
    else $error("pin low did not reset chip");
  a_wdt_reset: assert property (wdtResetReq [*2] |-> !sysResetN)
    else $error("watchdog did not reset chip");
  a_init_pair: assert property (ircStart |-> flashInit && !sysResetN ##1 !ircStart)
    else $error("oscillator start without flash init");
  a_fetch_zero: assert property ($rose(sysResetN) |=> cpuFetchStart && cpuFetchAddr == 32'h0)
    else $error("no fetch from zero after release");

  // ----------------------------------------
  // Access gating and pin selection
  // ----------------------------------------
  a_swd_gated: assert property (swdEnable |-> sysResetN && !jtagMode)
    else $error("serial debug on in reset or scan");
  a_pin_selects: assert property (!resetPinN [*3] |-> jtagMode)
    else $error("pin low did not select scan");
  a_scan_pins: assert property (jtagMode |-> gpioIn == 4'h0 && p0OeN[3] == !jtagTdoEn)
    else $error("scan pins not routed");
  a_scan_no_debug: assert property (jtagMode |-> !debugApEnable)
    else $error("debug reachable in scan mode");
  a_iap_always: assert property (iapEnable)
    else $error("application programming blocked");
  a_lvl3_block: assert property (ispCmdSet == 4'h8 |-> !entryPinHonor && !swdEnable)
    else $error("level three left access open");
endmodule

bind rbdac_top rbdac_top_properties chk (.mclk(mclk), .resetn(resetn), .resetPinN(resetPinN),
  .wdtResetReq(wdtResetReq), .sysResetN(sysResetN), .cpuFetchStart(cpuFetchStart),
  .cpuFetchAddr(cpuFetchAddr), .ircStart(ircStart), .flashInit(flashInit),
  .swdEnable(swdEnable), .debugApEnable(debugApEnable), .iapEnable(iapEnable),
  .entryPinHonor(entryPinHonor), .ispCmdSet(ispCmdSet), .jtagMode(jtagMode),
  .gpioIn(gpioIn), .p0OeN(p0OeN), .jtagTdoEn(jtagTdoEn));

// >>> tb/rbdac_host_model.sv
// External reset driver and boundary-scan host on the reset pin and port zero
`timescale 1ns/100ps
module rbdac_host_model (
  input wire logic mclk,
  input wire logic [3:0] p0Out,
  input wire logic [3:0] p0OeN,
  output logic resetPinN,
  output logic [3:0] p0In
);
  logic [3:0] hostDrv = 4'h0;

  initial resetPinN = 1'h1;
  // Device wins where its enable is low; host drives the rest
  assign p0In = (~p0OeN & p0Out) | (p0OeN & hostDrv);

  task automatic pulse(input int n);
    @(posedge mclk);
    resetPinN <= 1'h0;
    repeat (n) @(posedge mclk);
    resetPinN <= 1'h1;
  endtask

  // ----------------------------------------
  // Scan entry: pin held high first, then low
  // ----------------------------------------
  task automatic scan(input logic [2:0] v);
    repeat (6250) @(posedge mclk);
    resetPinN <= 1'h0;
    hostDrv[2:0] <= v;
  endtask

  task automatic scan_end;
    @(posedge mclk);
    resetPinN <= 1'h1;
  endtask
endmodule

// >>> tb/tb_top.sv
// Register, reset-source, protection and scan scenarios for the reset controller
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'h0, resetn = 1'h0, wdtResetReq = 1'h0, porDetect = 1'h0, supplyOk = 1'h1;
  logic flashInitDone = 1'h1, jtagTdo = 1'h0, jtagTdoEn = 1'h0, resetPinN;
  logic [3:0] vddBelowLevel = 4'h0, gpioOut = 4'h0, gpioOeN = 4'hF, s_axi_wstrb = 4'hF;
  logic [31:0] protWord = 32'h0, cpuFetchAddr, s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] p0In, p0Out, p0OeN, gpioIn, ispCmdSet, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic ircStart, flashInit, sysResetN, cpuFetchStart, bodIrq, swdEnable, debugApEnable;
  logic iapEnable, entryPinHonor, jtagMode, jtagTms, jtagTck, jtagTdi;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] patTab [5] = '{32'h0, 32'h11, 32'h22, 32'h33, 32'h44};
  logic [31:0] accTab [5] = '{32'h11, 32'h12, 32'h14, 32'h08, 32'h01};
  logic [3:0] ispTab [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
  int n_fail = 0, checks_done = 0, nIrc = 0, nFetch = 0, nRst = 0;

  always #20 mclk = ~mclk;

  rbdac_top uut (.mclk(mclk), .resetn(resetn), .resetPinN(resetPinN), .wdtResetReq(wdtResetReq),
    .porDetect(porDetect), .supplyOk(supplyOk), .vddBelowLevel(vddBelowLevel),
    .ircStart(ircStart), .flashInit(flashInit), .flashInitDone(flashInitDone),
    .protWord(protWord), .sysResetN(sysResetN), .cpuFetchStart(cpuFetchStart),
    .cpuFetchAddr(cpuFetchAddr), .bodIrq(bodIrq), .swdEnable(swdEnable),
    .debugApEnable(debugApEnable), .iapEnable(iapEnable), .entryPinHonor(entryPinHonor),
    .ispCmdSet(ispCmdSet), .jtagMode(jtagMode), .p0In(p0In), .p0Out(p0Out), .p0OeN(p0OeN),
    .gpioOut(gpioOut), .gpioOeN(gpioOeN), .gpioIn(gpioIn), .jtagTms(jtagTms),
    .jtagTck(jtagTck), .jtagTdi(jtagTdi), .jtagTdo(jtagTdo), .jtagTdoEn(jtagTdoEn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  rbdac_host_model host (.mclk(mclk), .p0Out(p0Out), .p0OeN(p0OeN), .resetPinN(resetPinN),
    .p0In(p0In));

  always @(negedge mclk) begin
    if (ircStart === 1'h1 && flashInit === 1'h1) nIrc++;
    if (cpuFetchStart === 1'h1 && cpuFetchAddr === 32'h0) nFetch++;
  end

  // ----------------------------------------
  // Comparison, verdict and bounded waits
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic hang(input bit t);
    if (t) begin
      n_fail++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  endtask

  task automatic wrs(input logic v);
    int n = 0;
    while (sysResetN !== v && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    hang(n >= 20000);
  endtask

  // Every chip reset restarts the oscillator once and refetches once
  task automatic done_rst;
    nRst++;
    wrs(1'h1);
    repeat (3) @(negedge mclk);
    chk(nIrc, nRst);
    chk(nFetch, nRst);
  endtask

  // ----------------------------------------
  // AXI4-Lite master; handshakes sampled mid-cycle
  // ----------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n = 0;
    b = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b && n < 50) begin
      @(negedge mclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid === 1'h1;
      r = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    hang(!b);
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int n = 0;
    v = 1'h0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!v && n < 50) begin
      @(negedge mclk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid === 1'h1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    hang(!v);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    axr(a, rd, resp);
    chk(rd, e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    done_rst();
    $display("test boot done");
    rchk(4'h0, 32'h0);
    axw(4'h0, 32'hFFFF_FFEF, resp);
    chk(32'(resp), 32'h0);
    axw(4'h4, 32'h1, resp);
    chk(32'(resp), 32'h2);
    rchk(4'h0, 32'h0000_000F);
    rchk(4'h8, 32'h0);
    axr(4'h2, rd, resp);
    chk(32'(resp), 32'h2);
    $display("test registers done");
    host.pulse(2);
    wrs(1'h0);
    done_rst();
    rchk(4'h0, 32'h0);
    rchk(4'h8, 32'h1);
    // Without a usable supply the restart must wait
    @(posedge mclk);
    supplyOk <= 1'h0;
    host.pulse(2);
    wrs(1'h0);
    repeat (8) @(negedge mclk);
    chk(nIrc, nRst);
    chk(32'(sysResetN), 32'h0);
    @(posedge mclk);
    supplyOk <= 1'h1;
    done_rst();
    for (int k = 1; k < 3; k++) begin
      axw(4'h8, 32'hF, resp);
      @(posedge mclk);
      {porDetect, wdtResetReq} <= k[1:0];
      wrs(1'h0);
      @(posedge mclk);
      {porDetect, wdtResetReq} <= 2'h0;
      done_rst();
      rchk(4'h8, 32'h1 << k);
    end
    $display("test reset sources done");
    for (int k = 0; k < 4; k++) begin
      axw(4'h8, 32'hF, resp);
      axw(4'h0, 32'(k * 5), resp);
      @(posedge mclk);
      vddBelowLevel <= 4'h1 << k;
      repeat (4) @(negedge mclk);
      chk(32'(bodIrq), 32'h1);
      rchk(4'h4, 32'((32'h1 << (k + 1)) | 32'h1));
      axw(4'h0, 32'((k + 1) % 4), resp);
      @(negedge mclk);
      chk(32'(bodIrq), 32'h0);
      @(posedge mclk);
      vddBelowLevel <= 4'h0;
      axw(4'h0, 32'(k * 5 + 16), resp);
      @(posedge mclk);
      vddBelowLevel <= 4'h1 << k;
      wrs(1'h0);
      @(posedge mclk);
      vddBelowLevel <= 4'h0;
      done_rst();
      rchk(4'h8, 32'h8);
    end
    $display("test brownout done");
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      protWord <= patTab[k];
      host.pulse(2);
      wrs(1'h0);
      done_rst();
      rchk(4'hC, accTab[k]);
      chk(32'(ispCmdSet), 32'(ispTab[k]));
      chk(32'(swdEnable), 32'(k == 0 || k == 4));
      chk(32'(iapEnable), 32'h1);
    end
    $display("test protection done");
    @(posedge mclk);
    gpioOut <= 4'h5;
    gpioOeN <= 4'h0;
    jtagTdoEn <= 1'h1;
    jtagTdo <= 1'h1;
    @(negedge mclk);
    chk(32'(p0Out), 32'h5);
    host.scan(3'h2);
    // Held well past the pin counter's range
    repeat (20) @(negedge mclk);
    chk(32'(jtagMode), 32'h1);
    chk(32'({jtagTdi, jtagTck, jtagTms}), 32'h2);
    chk(32'(p0OeN), 32'h7);
    chk(32'(p0Out[3]), 32'h1);
    chk(32'(debugApEnable), 32'h0);
    chk(32'(sysResetN), 32'h0);
    host.scan_end();
    done_rst();
    chk(32'(jtagMode), 32'h0);
    $display("test scan done");
    report_and_stop();
  end
endmodule
